// *** rtl/sdc_shift_divide.sv ***
// Shift and divide control with its Wishbone register slave
`timescale 1ns/10ps

module sdc_shift_divide (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic writeBackReq,
  output logic fetchInhibit,
  output logic reloadReq
);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // Byte-lane merge for the 24-bit data registers
  function automatic logic [23:0] mergeBytes(input logic [23:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] sel);
    logic [23:0] res;
    res = old;
    for (int i = 0; i < 3; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Sub-orders that run the shift-cycle pair
  function automatic logic usesCycles(input logic [2:0] sub);
    return (sub == sdc_pkg::SUB_MUL) || (sub == sdc_pkg::SUB_DIV) ||
           (sub == sdc_pkg::SUB_UNTIL_DIFF);
  endfunction

  // Sub-orders that step the repeat counter
  function automatic logic stepsRepeat(input logic [2:0] sub);
    return (sub == sdc_pkg::SUB_LSH) || (sub == sdc_pkg::SUB_SCA) ||
           (sub == sdc_pkg::SUB_SCL) || (sub == sdc_pkg::SUB_UNTIL_DIFF);
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  sdc_pkg::sdc_state_type state;
  logic [23:0] acc;
  logic [23:0] memIo;
  logic [23:0] divisor;
  logic [2:0] suborder;
  logic [1:0] shiftType;
  logic mode;
  logic bitsDiff;
  logic initiate;
  logic reload;
  logic [1:0] reloadStep;
  logic repeat_clear_add_mode;
  logic [31:0] readMux;

  sdc_cnt_if kIf ();
  sdc_cnt_if rcIf ();

  sdc_down_counter u_shift_cnt (.clk(clk), .rst_n(rst_n), .port(kIf));
  sdc_down_counter u_repeat_cnt (.clk(clk), .rst_n(rst_n), .port(rcIf));

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // A write lands on the edge that samples ack, as classic cycles expect
  logic req;
  logic wrTake;
  logic idle;
  logic wrInstr;
  logic wrCmd;
  logic wrCw1;
  logic wrCw2;
  logic [5:0] opcode;
  logic noIndex;
  logic goCmd;
  logic needInit;
  logic scaled;
  logic noShift;
  logic rcCounts;
  logic diffNow;
  logic rcStop;
  logic stopNow;
  logic endsWithWrite;
  logic [23:0] xShift;
  logic [24:0] divSum;
  logic [24:0] mulSum;

  assign req = wb_cyc_i & wb_stb_i;
  assign wrTake = req & wb_ack_o & wb_we_i;
  assign idle = (state == sdc_pkg::S_IDLE);
  assign wrInstr = wrTake & idle & (wb_adr_i == sdc_pkg::OFS_INSTR);
  assign wrCmd = wrTake & (wb_adr_i == sdc_pkg::OFS_CMD);
  assign wrCw1 = wrTake & idle & (wb_adr_i == sdc_pkg::OFS_CWORD1);
  assign wrCw2 = wrTake & idle & (wb_adr_i == sdc_pkg::OFS_CWORD2);
  assign opcode = wb_dat_i[sdc_pkg::OPC_HI:sdc_pkg::OPC_LO];
  assign noIndex = (wb_dat_i[sdc_pkg::XREG_HI:sdc_pkg::XREG_LO] == 5'h00);
  assign goCmd = wrCmd & idle & wb_dat_i[sdc_pkg::CMD_GO];

  // ----------------------------------------------------------------------
  // Start and stop conditions
  // ----------------------------------------------------------------------
  // Until-different and repeat type 1X wait on the initiate condition
  assign needInit = (suborder == sdc_pkg::SUB_UNTIL_DIFF) |
                    (repeat_clear_add_mode & shiftType[1]);
  assign scaled = ((suborder == sdc_pkg::SUB_SCA) & (acc[23] ^ acc[22])) |
                  ((suborder == sdc_pkg::SUB_SCL) &
                   (memIo[22] ^ memIo[21]));
  assign noShift = kIf.zero | scaled;
  assign rcCounts = ~mode & stepsRepeat(suborder);
  assign diffNow = (suborder == sdc_pkg::SUB_SCL) ?
                   (memIo[22] ^ memIo[21]) : (acc[23] ^ acc[22]);
  // Refill count exhausted in the shifts that own a refill count
  assign rcStop = rcCounts & rcIf.zero &
                  ((suborder == sdc_pkg::SUB_UNTIL_DIFF) |
                   ((suborder == sdc_pkg::SUB_LSH) & repeat_clear_add_mode &
                    ~shiftType[1]));
  assign stopNow = kIf.zero | rcStop |
                   (diffNow & ((suborder == sdc_pkg::SUB_UNTIL_DIFF) |
                               (suborder == sdc_pkg::SUB_SCA) |
                               (suborder == sdc_pkg::SUB_SCL)));
  assign endsWithWrite = (suborder == sdc_pkg::SUB_DIV) |
                         (suborder == sdc_pkg::SUB_MUL) |
                         (suborder == sdc_pkg::SUB_SCL);

  // Divide trial: the stored complement plus one subtracts the divisor
  assign xShift = {memIo[22:0], acc[23]};
  assign divSum = {1'b0, xShift} + {1'b0, divisor} + 25'h000_0001;
  assign mulSum = {1'b0, memIo} + (acc[0] ? {1'b0, divisor} : 25'h000_0000);

  // ----------------------------------------------------------------------
  // Counter controls
  // ----------------------------------------------------------------------
  always_comb begin
    kIf.load = wrInstr & (opcode == sdc_pkg::OPC_SHIFT);
    kIf.loadVal = wb_dat_i[sdc_pkg::CNT_HI:sdc_pkg::CNT_LO];
    kIf.dec = (state == sdc_pkg::S_CTRL1);
    rcIf.load = (wrInstr & (opcode == sdc_pkg::OPC_LOAD_INDEX) & noIndex) |
                wrCw1 | wrCw2;
    rcIf.loadVal = wb_dat_i[sdc_pkg::CNT_HI:sdc_pkg::CNT_LO];
    rcIf.dec = (state == sdc_pkg::S_CTRL1) & rcCounts;
  end

  // ----------------------------------------------------------------------
  // Shift timing chain
  // ----------------------------------------------------------------------
  // The cycle pair only runs for the three operations that need it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= sdc_pkg::S_IDLE;
    end else begin
      unique case (state)
        sdc_pkg::S_IDLE: begin
          if (goCmd & ~noShift & (~needInit | rcIf.zero)) begin
            state <= sdc_pkg::S_CTRL1;
          end
        end
        sdc_pkg::S_CTRL1: begin
          state <= sdc_pkg::S_CTRL2;
        end
        sdc_pkg::S_CTRL2: begin
          state <= usesCycles(suborder) ? sdc_pkg::S_CYC1 :
                                          sdc_pkg::S_TEST;
        end
        sdc_pkg::S_CYC1: begin
          state <= sdc_pkg::S_CYC2;
        end
        sdc_pkg::S_CYC2: begin
          state <= sdc_pkg::S_TEST;
        end
        sdc_pkg::S_TEST: begin
          state <= stopNow ? sdc_pkg::S_IDLE :
                             sdc_pkg::S_CTRL1;
        end
        default: begin
          state <= sdc_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Shift function register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      suborder <= sdc_pkg::SUB_LSH;
      shiftType <= 2'h0;
      mode <= 1'b0;
    end else if (wrInstr & (opcode == sdc_pkg::OPC_SHIFT)) begin
      suborder <= wb_dat_i[sdc_pkg::SUB_HI:sdc_pkg::SUB_LO];
      shiftType <= wb_dat_i[sdc_pkg::TYPE_HI:sdc_pkg::TYPE_LO];
      mode <= wb_dat_i[sdc_pkg::MODE_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------------
  // Software writes stand for memory reads; they are held off while busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      memIo <= '0;
    end else if (state == sdc_pkg::S_CTRL1) begin
      unique case (suborder)
        sdc_pkg::SUB_DIV: begin
          acc <= {acc[22:0], divSum[24]};
          memIo <= divSum[24] ? divSum[23:0] : xShift;
        end
        sdc_pkg::SUB_MUL: begin
          memIo <= mulSum[24:1];
          acc <= {mulSum[0], acc[23:1]};
        end
        sdc_pkg::SUB_SCL: begin
          memIo <= {memIo[22:0], acc[23]};
          acc <= {acc[22:0], memIo[23]};
        end
        sdc_pkg::SUB_RSH: begin
          acc <= {acc[0], acc[23:1]};
        end
        sdc_pkg::SUB_LSH, sdc_pkg::SUB_SCA, sdc_pkg::SUB_UNTIL_DIFF: begin
          acc <= {acc[22:0], acc[23]};
        end
        default: begin
          acc <= acc;
        end
      endcase
    end else if (goCmd & (suborder == sdc_pkg::SUB_MUL)) begin
      memIo <= '0;
    end else if (wrInstr & (opcode == sdc_pkg::OPC_STORE_INDEX) &
                 noIndex) begin
      memIo <= {19'h0_0000, rcIf.count};
    end else if (wrTake & idle) begin
      if (wb_adr_i == sdc_pkg::OFS_ACC) begin
        acc <= mergeBytes(acc, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == sdc_pkg::OFS_MEMIO) begin
        memIo <= mergeBytes(memIo, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Divisor is kept complemented for divide so the adder subtracts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divisor <= '0;
    end else if (wrTake & idle & (wb_adr_i == sdc_pkg::OFS_DIVISOR)) begin
      divisor <= mergeBytes(divisor,
                            (suborder == sdc_pkg::SUB_DIV) ?
                            ~wb_dat_i : wb_dat_i, wb_sel_i);
    end
  end

  // ----------------------------------------------------------------------
  // Shift control flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitsDiff <= 1'b0;
      initiate <= 1'b0;
    end else if (goCmd) begin
      bitsDiff <= 1'b0;
      initiate <= needInit & rcIf.zero;
    end else if ((state == sdc_pkg::S_TEST) & stopNow) begin
      bitsDiff <= diffNow & (suborder != sdc_pkg::SUB_DIV) &
                  (suborder != sdc_pkg::SUB_MUL);
      initiate <= 1'b0;
    end
  end

  // Write-back request and fetch inhibit; a set beats a same-cycle clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      writeBackReq <= 1'b0;
      fetchInhibit <= 1'b0;
    end else begin
      if (wrCmd & wb_dat_i[sdc_pkg::CMD_WBDONE]) begin
        writeBackReq <= 1'b0;
        fetchInhibit <= 1'b0;
      end
      if (goCmd & noShift & endsWithWrite) begin
        writeBackReq <= 1'b1;
      end
      if ((state == sdc_pkg::S_TEST) & stopNow & endsWithWrite) begin
        writeBackReq <= 1'b1;
        if ((suborder == sdc_pkg::SUB_SCL) & diffNow) begin
          fetchInhibit <= 1'b1;
        end
      end
      if (wrInstr & (opcode == sdc_pkg::OPC_STORE_INDEX) & noIndex) begin
        writeBackReq <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Reload sequencing
  // ----------------------------------------------------------------------
  // Phase one is acknowledged by software; then three further steps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reloadReq <= 1'b0;
      reload <= 1'b0;
      reloadStep <= 2'h0;
    end else begin
      if (wrCmd & wb_dat_i[sdc_pkg::CMD_RL1] & reloadReq) begin
        reloadReq <= 1'b0;
        reload <= 1'b1;
        reloadStep <= 2'h0;
      end else if (wrCmd & wb_dat_i[sdc_pkg::CMD_STEP] & reload) begin
        if (reloadStep == sdc_pkg::RELOAD_LAST) begin
          reload <= 1'b0;
          reloadStep <= 2'h0;
        end else begin
          reloadStep <= reloadStep + 2'h1;
        end
      end
      if ((state == sdc_pkg::S_TEST) & rcStop) begin
        reloadReq <= 1'b1;
      end
    end
  end

  // Repeat-clear-add mode flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      repeat_clear_add_mode <= 1'b0;
    end else if (wrInstr & (opcode == sdc_pkg::OPC_REPEAT_MODE)) begin
      repeat_clear_add_mode <= 1'b1;
    end else if ((wrInstr & (opcode == sdc_pkg::OPC_ENDRPT)) |
                 ((wrCw1 | wrCw2) &
                  (wb_dat_i[sdc_pkg::CNT_HI:sdc_pkg::CNT_LO] == 5'h00)) |
                 (wrCw2 &
                  (wb_dat_i[sdc_pkg::WC_HI:sdc_pkg::WC_LO] == 10'h000))) begin
      repeat_clear_add_mode <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone answer
  // ----------------------------------------------------------------------
  always_comb begin
    readMux = '0;
    unique case (wb_adr_i)
      sdc_pkg::OFS_ACC: readMux[23:0] = acc;
      sdc_pkg::OFS_MEMIO: readMux[23:0] = memIo;
      sdc_pkg::OFS_DIVISOR: readMux[23:0] = divisor;
      sdc_pkg::OFS_STATUS: begin
        readMux[4:0] = kIf.count;
        readMux[sdc_pkg::ST_RC_LO +: 5] = rcIf.count;
        readMux[12:10] = suborder;
        readMux[14:13] = shiftType;
        readMux[15] = mode;
        readMux[sdc_pkg::ST_BUSY] = ~idle;
        readMux[sdc_pkg::ST_DIFF] = bitsDiff;
        readMux[sdc_pkg::ST_INIT] = initiate;
        readMux[sdc_pkg::ST_RLREQ] = reloadReq;
        readMux[sdc_pkg::ST_RELOAD] = reload;
        readMux[sdc_pkg::ST_WBREQ] = writeBackReq;
        readMux[sdc_pkg::ST_INHIBIT] = fetchInhibit;
        readMux[sdc_pkg::ST_REPEAT_MODE] = repeat_clear_add_mode;
        readMux[sdc_pkg::ST_STEP_LO +: 2] = reloadStep;
      end
      default: readMux = '0;
    endcase
  end

  // One wait state; ack drops the cycle after it is given
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o) begin
        wb_dat_o <= readMux;
      end
    end
  end

endmodule

// *** inc/sdc_pkg.sv ***
// Constants and types shared by the shift and divide control block
package sdc_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int CNT_W = 5;
  localparam int BUS_W = 32;
  localparam int ADR_W = 8;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [ADR_W-1:0] OFS_INSTR = 8'h00;
  localparam logic [ADR_W-1:0] OFS_ACC = 8'h04;
  localparam logic [ADR_W-1:0] OFS_MEMIO = 8'h08;
  localparam logic [ADR_W-1:0] OFS_DIVISOR = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_CMD = 8'h10;
  localparam logic [ADR_W-1:0] OFS_CWORD1 = 8'h14;
  localparam logic [ADR_W-1:0] OFS_CWORD2 = 8'h18;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h1C;

  // ----------------------------------------------------------------------
  // Instruction and control word fields
  // ----------------------------------------------------------------------
  localparam int OPC_HI = 23;
  localparam int OPC_LO = 18;
  localparam int SUB_HI = 7;
  localparam int SUB_LO = 5;
  localparam int TYPE_HI = 13;
  localparam int TYPE_LO = 12;
  localparam int MODE_BIT = 11;
  localparam int CNT_HI = 4;
  localparam int CNT_LO = 0;
  localparam int XREG_HI = 13;
  localparam int XREG_LO = 9;
  localparam int WC_HI = 23;
  localparam int WC_LO = 14;

  // Operation codes (octal 06, 24, 25, 26, 27)
  localparam logic [5:0] OPC_SHIFT = 6'h06;
  localparam logic [5:0] OPC_REPEAT_MODE = 6'h14;
  localparam logic [5:0] OPC_ENDRPT = 6'h15;
  localparam logic [5:0] OPC_STORE_INDEX = 6'h16;
  localparam logic [5:0] OPC_LOAD_INDEX = 6'h17;

  // Shift sub-orders
  localparam logic [2:0] SUB_LSH = 3'h0;
  localparam logic [2:0] SUB_DIV = 3'h1;
  localparam logic [2:0] SUB_SCA = 3'h2;
  localparam logic [2:0] SUB_SCL = 3'h3;
  localparam logic [2:0] SUB_RSH = 3'h4;
  localparam logic [2:0] SUB_MUL = 3'h5;
  localparam logic [2:0] SUB_UNTIL_DIFF = 3'h6;

  // Command register bits
  localparam int CMD_GO = 0;
  localparam int CMD_RL1 = 1;
  localparam int CMD_STEP = 2;
  localparam int CMD_WBDONE = 3;

  // Status register bits
  localparam int ST_RC_LO = 5;
  localparam int ST_BUSY = 16;
  localparam int ST_DIFF = 17;
  localparam int ST_INIT = 18;
  localparam int ST_RLREQ = 19;
  localparam int ST_RELOAD = 20;
  localparam int ST_WBREQ = 21;
  localparam int ST_INHIBIT = 22;
  localparam int ST_REPEAT_MODE = 23;
  localparam int ST_STEP_LO = 24;

  localparam logic [1:0] RELOAD_LAST = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE, S_CTRL1, S_CTRL2, S_CYC1, S_CYC2, S_TEST
  } sdc_state_type;

endpackage

// *** inc/sdc_cnt_if.sv ***
// Load, decrement and zero signals between control and a down counter
`timescale 1ns/10ps
interface sdc_cnt_if;
  logic load;
  logic [4:0] loadVal;
  logic dec;
  logic [4:0] count;
  logic zero;
  modport ctl (output load, output loadVal, output dec,
               input count, input zero);
  modport cnt (input load, input loadVal, input dec,
               output count, output zero);
endinterface

// *** rtl/sdc_down_counter.sv ***
// Five-bit double-rank down counter
`timescale 1ns/10ps
module sdc_down_counter (
  input wire logic clk,
  input wire logic rst_n,
  sdc_cnt_if.cnt port
);

  logic [4:0] rank;
  logic pending;

  // ----------------------------------------------------------------------
  // First rank takes the decremented value, second rank follows
  // ----------------------------------------------------------------------
  // Zero is only read after the transfer, so it never sees a half step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rank <= '0;
      pending <= 1'b0;
      port.count <= '0;
    end else if (port.load) begin
      rank <= port.loadVal;
      pending <= 1'b0;
      port.count <= port.loadVal;
    end else if (port.dec) begin
      rank <= port.count - 5'h01;
      pending <= 1'b1;
    end else if (pending) begin
      port.count <= rank;
      pending <= 1'b0;
    end
  end

  // Zero indication
  assign port.zero = (port.count == 5'h00);

endmodule

// *** tb/sdc_shift_divide_assertions.sv ***
// Checker for the bus handshake and control flags of the block
`timescale 1ns/10ps
module sdc_shift_divide_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic writeBackReq,
  input wire logic fetchInhibit,
  input wire logic reloadReq
);
  logic req;
  logic cmdWr;
  // Request seen, and a command write at its ack edge
  assign req = wb_cyc_i && wb_stb_i;
  assign cmdWr = wb_ack_o && wb_we_i && wb_adr_i == sdc_pkg::OFS_CMD;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // One answer per request, exactly one cycle late
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_ack_delay: assert property (req && !$past(req) |=> wb_ack_o)
    else $error("ack late");
  chk_ack_cause: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  chk_rdata_hold: assert property (!req |=> $stable(wb_dat_o))
    else $error("read data moved");
  chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i > sdc_pkg::OFS_STATUS |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // Write-back request drops when the sequencer reports the cycle done; reload request drops on phase one
  chk_wb_done: assert property (cmdWr && wb_dat_i[sdc_pkg::CMD_WBDONE] |=>
    !writeBackReq)
    else $error("write-back stuck");
  chk_reload_go: assert property (cmdWr && wb_dat_i[1] && reloadReq |=> !reloadReq)
    else $error("reload request stuck");
  chk_inhibit_wb: assert property ($rose(fetchInhibit) |-> writeBackReq)
    else $error("inhibit without write-back");
  chk_reset_quiet: assert property ($rose(rst_n) |->
    !(writeBackReq || fetchInhibit || reloadReq))
    else $error("flag up after reset");
  cover property ($rose(writeBackReq));
  cover property ($rose(reloadReq));
  cover property ($rose(fetchInhibit));
endmodule
bind sdc_shift_divide sdc_shift_divide_checker u_chk (.clk, .rst_n,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
  .wb_dat_o, .wb_ack_o, .writeBackReq, .fetchInhibit, .reloadReq);

// *** tb/sdc_seq_model.sv ***
// Sequencer stand-in: counts the write-back cycles it is asked for
`timescale 1ns/10ps
module sdc_seq_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic writeBackReq,
  output int wbCount
);
  logic wbLast;
  // A level request means one memory cycle, so count rising edges only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wbLast <= 1'b0;
      wbCount <= 0;
    end else begin
      wbLast <= writeBackReq;
      if (writeBackReq && !wbLast) wbCount <= wbCount + 1;
    end
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the shift and divide control block
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dout;
  logic ack;
  logic wbReq;
  logic inhibit;
  logic rlReq;
  int wbCount;
  int mismatches = 0;
  int checked = 0;
  // Free-running 100 MHz clock
  always #5 clk = ~clk;
  sdc_shift_divide u_dut (.clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
    .wb_dat_o(dout), .wb_ack_o(ack), .writeBackReq(wbReq),
    .fetchInhibit(inhibit), .reloadReq(rlReq));
  sdc_seq_model u_seq (.clk, .rst_n, .writeBackReq(wbReq), .wbCount);
  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dout;
    if (n >= 20) mismatches++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ins(input logic [31:0] d);
    wb(1'b1, sdc_pkg::OFS_INSTR, d);
  endtask
  task automatic cmd(input logic [31:0] d);
    wb(1'b1, sdc_pkg::OFS_CMD, d);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Poll status until the shift sequence is over; ends with status read
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      wb(1'b0, sdc_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rdat[sdc_pkg::ST_BUSY] !== 1'b0 && n < 200);
    if (n >= 200) mismatches++;
  endtask
  task automatic test_decode;
    logic [2:0] s;
    for (int i = 0; i < 8; i++) begin
      s = i[2:0];
      ins(32'h0018_0000 | {s[1:0], s[0], 3'h0, s, 5'(i + 3)});
      wb(1'b0, sdc_pkg::OFS_STATUS, 32'h0);
      check(rdat & 32'h0000_FC1F, {s[0], s[1:0], s, 5'h00, 5'(i + 3)});
    end
    wb(1'b0, 8'h40, 32'h0);
    check(rdat, 32'h0);
    $display("decode done");
  endtask
  task automatic test_divide;
    logic [23:0] z;
    logic [23:0] a;
    logic [23:0] s;
    z = 24'h00_0123;
    a = 24'h45_6789;
    ins(32'h0018_0837);
    wb(1'b1, sdc_pkg::OFS_ACC, {8'h00, a});
    wb(1'b1, sdc_pkg::OFS_MEMIO, {8'h00, z});
    wb(1'b1, sdc_pkg::OFS_DIVISOR, 32'h0000_1000);
    cmd(32'h1);
    wait_idle();
    // Restoring division worked out step by step
    for (int k = 0; k < 23; k++) begin
      s = {z[22:0], a[23]};
      a = {a[22:0], s >= 24'h00_1000};
      z = s >= 24'h00_1000 ? s - 24'h00_1000 : s;
    end
    check(rdat & 32'h0000_001F, 32'h0);
    wb(1'b0, sdc_pkg::OFS_ACC, 32'h0);
    check(rdat, {8'h00, a});
    wb(1'b0, sdc_pkg::OFS_MEMIO, 32'h0);
    check(rdat, {8'h00, z});
    check(32'(wbReq), 32'h1);
    cmd(32'h8);
    check(32'(wbReq), 32'h0);
    $display("divide done");
  endtask
  task automatic test_scale;
    ins(32'h005C_0019);
    ins(32'h0018_007F);
    wb(1'b1, sdc_pkg::OFS_ACC, 32'h0);
    wb(1'b1, sdc_pkg::OFS_MEMIO, 32'h1);
    cmd(32'h1);
    wait_idle();
    check(rdat & 32'h0000_03FF, 32'h0000_008A);
    wb(1'b0, sdc_pkg::OFS_MEMIO, 32'h0);
    check(rdat, 32'h0020_0000);
    check(32'({inhibit, wbReq}), 32'h3);
    cmd(32'h8);
    $display("scale done");
  endtask
  task automatic test_until_diff;
    ins(32'h0018_08DF);
    wb(1'b1, sdc_pkg::OFS_ACC, 32'h1);
    cmd(32'h1);
    wait_idle();
    check(rdat & 32'h0000_03FF, 32'h0000_009F);
    ins(32'h005C_0000);
    ins(32'h0018_08DF);
    cmd(32'h1);
    wait_idle();
    check(rdat & 32'h0000_03FF, 32'h9);
    wb(1'b0, sdc_pkg::OFS_ACC, 32'h0);
    check(rdat, 32'h0040_0000);
    $display("until-different done");
  endtask
  task automatic test_reload;
    ins(32'h0050_0000);
    ins(32'h005C_0002);
    ins(32'h0018_0005);
    cmd(32'h1);
    wait_idle();
    check(rdat & 32'h0080_03FF, 32'h0080_0003);
    check(32'(rlReq), 32'h1);
    cmd(32'h2);
    wb(1'b0, sdc_pkg::OFS_STATUS, 32'h0);
    check(rdat & 32'h0010_0000, 32'h0010_0000);
    repeat (3) cmd(32'h4);
    wb(1'b0, sdc_pkg::OFS_STATUS, 32'h0);
    check(rdat & 32'h0010_0000, 32'h0);
    ins(32'h005C_0013);
    ins(32'h0058_0000);
    wb(1'b0, sdc_pkg::OFS_MEMIO, 32'h0);
    check(rdat, 32'h13);
    check(32'(wbCount), 32'h3);
    ins(32'h0054_0000);
    wb(1'b0, sdc_pkg::OFS_STATUS, 32'h0);
    check(rdat & 32'h0080_0000, 32'h0);
    cmd(32'h8);
    $display("reload done");
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Reset for four cycles, then the scenarios in turn
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_decode();
    test_divide();
    test_scale();
    test_until_diff();
    test_reload();
    wrap_up();
  end
  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule
